// ---- rtl/intc_pkg.sv ----
// shared constants, types and helpers of the twelve-source interrupt controller
// assumes one clock domain and byte addresses on the low eight address bits
`default_nettype none

package intc_pkg;

	localparam int NUM_SOURCES = 12;
	localparam int NUM_PORT1 = 8;

	// register byte addresses
	localparam logic [7:0] ADDR_EN_MAIN = 8'ha8;
	localparam logic [7:0] ADDR_LVL_MAIN = 8'hb8;
	localparam logic [7:0] ADDR_EN_PORT1 = 8'he8;
	localparam logic [7:0] ADDR_LVL_PORT1 = 8'hf8;
	localparam logic [7:0] ADDR_POLARITY = 8'hc0;
	localparam logic [7:0] ADDR_PENDING = 8'hc8;
	localparam logic [7:0] ADDR_EDGE_MODE = 8'hd0;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd8;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hdc;

	// field positions and masks
	localparam int GATE_BIT = 7;
	localparam logic [7:0] EN_MAIN_MASK = 8'h8f;
	localparam logic [7:0] LVL_MAIN_MASK = 8'h7f;
	localparam int SRC_PIN0 = 0;
	localparam int SRC_TIMER0 = 1;
	localparam int SRC_PIN1 = 2;
	localparam int SRC_TIMER1 = 3;
	localparam int EVT_WAKE = 0;
	localparam int EVT_PREEMPT = 1;
	localparam int NUM_EVENTS = 2;

	// service entry points: base plus a fixed stride per polling index
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;

	localparam logic [7:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] source;
		logic [15:0] vector;
	} core_req_type;

	typedef struct packed {
		logic busActive;
		logic busWrite;
		logic [7:0] busAddr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic [7:0] enMain;
		logic [7:0] lvlMain;
		logic [7:0] enPort1;
		logic [7:0] lvlPort1;
		logic [7:0] polarity;
		logic [1:0] edgeMode;
		logic [NUM_EVENTS-1:0] irqStatus;
		logic [NUM_EVENTS-1:0] irqMask;
		logic [1:0] extMeta;
		logic [1:0] extSync;
		logic [1:0] extPrev;
		logic [1:0] extFlag;
		logic [1:0] tmrFlag;
		logic [1:0] inService;
		core_req_type coreReq;
		logic wakeUp;
		logic irq;
	} ctrl_state_type;

	// pin synchronisers start at the idle high level so reset shows no false low or edge
	localparam ctrl_state_type STATE_RESET = '{hreadyout: 1'b1, extMeta: 2'b11, extSync: 2'b11,
		extPrev: 2'b11, default: '0};

	// lowest index wins; bit 4 marks that anything was found
	function automatic logic [4:0] pick_first(input logic [NUM_SOURCES-1:0] reqs);
		logic [4:0] res;
		res = 5'h00;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (reqs[i]) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	function automatic logic [15:0] vector_of(input logic [3:0] source);
		return 16'(VECTOR_BASE + VECTOR_STEP * {12'h000, source});
	endfunction

endpackage

`default_nettype wire

// ---- rtl/port1_line_detect.sv ----
// level detection and sticky pending flags for the port-1 request lines
// assumes pins are asynchronous; clearMask is a one-cycle write strobe
`default_nettype none

module port1_line_detect
	import intc_pkg::*;
#(
	parameter int WIDTH = NUM_PORT1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] linePins,
	input wire logic [WIDTH-1:0] polarity,
	input wire logic [WIDTH-1:0] clearMask,
	output logic [WIDTH-1:0] lineActive,
	output logic [WIDTH-1:0] pending
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] pending;
	} detect_state_type;

	detect_state_type q;
	detect_state_type d;

	// [RQ10] polarity per line
	assign lineActive = q.stable ~^ polarity;
	assign pending = q.pending;

	always_comb begin
		d = q;
		d.meta = linePins;
		d.stable = q.meta;
		// [RQ12] set wins over clear
		d.pending = (q.pending & ~clearMask) | lineActive;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// pins idle high on their pull-ups; zero here reads as an active-low request
			q <= '{meta: '1, stable: '1, pending: '0};
		end else begin
			q <= d;
		end
	end

endmodule // port1_line_detect

`default_nettype wire

// ---- rtl/twelve_source_two_level_interrupts.sv ----
// twelve-source, two-level vectored interrupt controller with an AHB-Lite register slave
// assumes one clock; timer overflows are same-clock pulses, pins are asynchronous
//
// Overview of operation
// [RQ1] twelve sources: two pin lines, two timer overflows, eight port-1 lines.
// [RQ2] an accepted request carries a fixed vector unique to its source.
// [RQ3] each source has an enable bit; one allows, zero blocks.
// [RQ4] main enable bit 7 gates every source when zero.
// [RQ5] main enable: timer1 bit 3, pin1 bit 2, timer0 bit 1, pin0 bit 0.
// [RQ6] port-1 enable bits 7..0 enable lines 9..2.
// [RQ7] each source has a level bit; one selects the higher level.
// [RQ8] main level: pin0 bit 0, timer0 bit 1, pin1 bit 2, timer1 bit 3.
// [RQ9] port-1 lines are level detected with per-line polarity select.
// [RQ10] each port-1 line may be active high or active low.
// [RQ11] an active enabled port-1 line wakes the device from power-down.
// [RQ12] port-1 pending flags set by hardware, cleared only by software.
// [RQ13] a flag still set after return raises a fresh request.
// [RQ14] port-1 level register at f8 maps lines 9..2 onto bits 7..0.
// [RQ15] port-1 lines 2..9 come from port 1 pins 0..7.
// [RQ16] higher level preempts lower; never same or lower level.
// [RQ17] same-level ties resolve pin0, timer0, pin1, timer1, lines 2..9.
// [RQ18] all enable, level, polarity and pending bits reset to zero.
//
// The AHB-Lite interface to the registers was left to the implementer.
`default_nettype none

module twelve_source_two_level_interrupts
	import intc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] extLines,
	input wire logic [1:0] timerOvf,
	input wire logic [NUM_PORT1-1:0] port1Pins,
	input wire logic powerDown,
	input wire logic ackTake,
	input wire logic retiDone,
	output core_req_type coreReq,
	output logic wakeUp,
	output logic irq
);

	ctrl_state_type q;
	ctrl_state_type d;

	logic take;
	logic busWrite;
	logic acked;
	logic preemptEvt;
	logic [1:0] extReq;
	logic [1:0] extFall;
	logic [1:0] extAckClr;
	logic [1:0] tmrAckClr;
	logic [NUM_SOURCES-1:0] ackOneHot;
	logic [NUM_SOURCES-1:0] srcFlags;
	logic [NUM_SOURCES-1:0] srcEnable;
	logic [NUM_SOURCES-1:0] srcLevel;
	logic [NUM_SOURCES-1:0] hiReq;
	logic [NUM_SOURCES-1:0] loReq;
	logic [4:0] hiPick;
	logic [4:0] loPick;
	logic [NUM_PORT1-1:0] port1Clear;
	logic [NUM_PORT1-1:0] port1Active;
	logic [NUM_PORT1-1:0] port1Pending;
	logic [NUM_PORT1-1:0] port1Keep;
	logic [NUM_EVENTS-1:0] statusClear;
	logic [NUM_EVENTS-1:0] events;

	// [RQ15] port 1 pin n feeds line n+2
	port1_line_detect #(
		.WIDTH(NUM_PORT1)
	) lineDetect (
		.clk(clk),
		.rst(rst),
		.linePins(port1Pins),
		.polarity(q.polarity),
		.clearMask(port1Clear),
		.lineActive(port1Active),
		.pending(port1Pending)
	);

	assign hreadyout = q.hreadyout;
	assign hresp = q.hresp;
	assign hrdata = q.hrdata;
	assign coreReq = q.coreReq;
	assign wakeUp = q.wakeUp;
	assign irq = q.irq;
	assign port1Keep = port1Pending & ~port1Clear;

	always_comb begin
		d = q;
		busWrite = 1'b0;
		port1Clear = '0;
		statusClear = '0;

		// one wait state on every transfer so read data can come from a flop
		take = hsel && htrans[1] && hready;
		if (take) begin
			d.busActive = 1'b1;
			d.busWrite = hwrite;
			d.busAddr = haddr[7:0];
			d.hreadyout = 1'b0;
		end
		if (q.busActive) begin
			d.busActive = 1'b0;
			d.hreadyout = 1'b1;
			busWrite = q.busWrite;
			if (!q.busWrite) begin
				case (q.busAddr)
					ADDR_EN_MAIN: d.hrdata = {24'h000000, q.enMain};
					ADDR_LVL_MAIN: d.hrdata = {24'h000000, q.lvlMain};
					ADDR_EN_PORT1: d.hrdata = {24'h000000, q.enPort1};
					ADDR_LVL_PORT1: d.hrdata = {24'h000000, q.lvlPort1};
					ADDR_POLARITY: d.hrdata = {24'h000000, q.polarity};
					ADDR_PENDING: d.hrdata = {24'h000000, port1Pending};
					ADDR_EDGE_MODE: d.hrdata = {30'h00000000, q.edgeMode};
					ADDR_IRQ_STATUS: d.hrdata = {30'h00000000, q.irqStatus};
					ADDR_IRQ_MASK: d.hrdata = {30'h00000000, q.irqMask};
					default: d.hrdata = 32'h00000000;
				endcase
			end
		end
		if (busWrite) begin
			case (q.busAddr)
				// [RQ5] unused main enable bits stay zero
				ADDR_EN_MAIN: d.enMain = hwdata[7:0] & EN_MAIN_MASK;
				// [RQ8] top level bit unused
				ADDR_LVL_MAIN: d.lvlMain = hwdata[7:0] & LVL_MAIN_MASK;
				// [RQ6] one enable per line
				ADDR_EN_PORT1: d.enPort1 = hwdata[7:0];
				// [RQ14] one level per line
				ADDR_LVL_PORT1: d.lvlPort1 = hwdata[7:0];
				// [RQ9] polarity select
				ADDR_POLARITY: d.polarity = hwdata[7:0];
				// [RQ12] software clears by writing ones
				ADDR_PENDING: port1Clear = hwdata[7:0];
				ADDR_EDGE_MODE: d.edgeMode = hwdata[1:0];
				ADDR_IRQ_STATUS: statusClear = hwdata[NUM_EVENTS-1:0];
				ADDR_IRQ_MASK: d.irqMask = hwdata[NUM_EVENTS-1:0];
				default: ;
			endcase
		end

		// pin lines: falling edge in edge mode, low level otherwise
		d.extMeta = extLines;
		d.extSync = q.extMeta;
		d.extPrev = q.extSync;
		extFall = q.extPrev & ~q.extSync;
		for (int i = 0; i < 2; i++) begin
			extReq[i] = q.edgeMode[i] ? q.extFlag[i] : ~q.extSync[i];
		end

		// [RQ1] twelve sources in polling order
		srcFlags = {port1Pending, q.tmrFlag[1], extReq[1], q.tmrFlag[0], extReq[0]};
		// [RQ3] per-source enable, [RQ4] global gate
		srcEnable = {q.enPort1, q.enMain[3:0]} & {NUM_SOURCES{q.enMain[GATE_BIT]}};
		// [RQ7] level bit one is the higher level
		srcLevel = {q.lvlPort1, q.lvlMain[3:0]};
		hiReq = srcFlags & srcEnable & srcLevel;
		loReq = srcFlags & srcEnable & ~srcLevel;
		// [RQ17] fixed polling order
		hiPick = pick_first(hiReq);
		loPick = pick_first(loReq);

		// [RQ13] a flag still set re-requests once its level is free
		// return first, so a same-cycle acceptance is kept
		if (retiDone) begin
			if (q.inService[1]) begin
				d.inService[1] = 1'b0;
			end else begin
				d.inService[0] = 1'b0;
			end
		end
		acked = ackTake && q.coreReq.valid;
		preemptEvt = acked && q.coreReq.high && q.inService[0];
		ackOneHot = acked ? (NUM_SOURCES'(1) << q.coreReq.source) : '0;
		if (acked) begin
			d.inService[q.coreReq.high] = 1'b1;
		end

		// edge and timer flags clear on acceptance, a new event wins
		extAckClr = {ackOneHot[SRC_PIN1], ackOneHot[SRC_PIN0]};
		tmrAckClr = {ackOneHot[SRC_TIMER1], ackOneHot[SRC_TIMER0]};
		d.extFlag = (q.extFlag & ~extAckClr) | (extFall & q.edgeMode);
		d.tmrFlag = (q.tmrFlag & ~tmrAckClr) | timerOvf;

		// dropped for one cycle after acceptance so the core never takes it twice
		d.coreReq = '0;
		if (!acked) begin
			// [RQ16] high preempts low, never same level
			if (hiPick[4] && !q.inService[1]) begin
				d.coreReq.valid = 1'b1;
				d.coreReq.high = 1'b1;
				d.coreReq.source = hiPick[3:0];
			end else if (loPick[4] && q.inService == 2'b00) begin
				d.coreReq.valid = 1'b1;
				d.coreReq.source = loPick[3:0];
			end
			// [RQ2] source-specific vector
			d.coreReq.vector = d.coreReq.valid ? vector_of(d.coreReq.source) : 16'h0000;
		end

		// [RQ11] wake on an active enabled line
		d.wakeUp = powerDown && (port1Active & q.enPort1) != '0;
		events = '0;
		events[EVT_WAKE] = d.wakeUp && !q.wakeUp;
		events[EVT_PREEMPT] = preemptEvt;
		d.irqStatus = (q.irqStatus & ~statusClear) | events;
		d.irq = (q.irqStatus & q.irqMask) != '0;
	end

	// [RQ18] registers clear on reset; hreadyout and the pin synchronisers start high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_bus_take;
		take;
	endsequence

	sequence s_wait_then_ready;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_bus_wait;
		s_bus_take |=> s_wait_then_ready;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait");

	property p_gate_blocks;
		!q.enMain[GATE_BIT] |=> !coreReq.valid;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("request while gate closed"); // RQ4

	property p_none_enabled;
		(srcEnable == '0) |=> !coreReq.valid;
	endproperty
	a_none_enabled: assert property (p_none_enabled) else $error("request with no enable"); // RQ3

	property p_vector;
		coreReq.valid |-> coreReq.vector == vector_of(coreReq.source);
	endproperty
	a_vector: assert property (p_vector) else $error("vector does not match source"); // RQ2

	property p_high_blocked;
		coreReq.valid |-> !q.inService[1];
	endproperty
	a_high_blocked: assert property (p_high_blocked) else $error("request over high routine"); // RQ16

	property p_low_blocked;
		coreReq.valid && !coreReq.high |-> q.inService == 2'b00;
	endproperty
	a_low_blocked: assert property (p_low_blocked) else $error("low request nested"); // RQ16

	sequence s_pin0_high_free;
		hiReq[SRC_PIN0] && !q.inService[1] && !acked;
	endsequence

	property p_poll;
		s_pin0_high_free |=> coreReq.valid && coreReq.high && coreReq.source == 4'h0;
	endproperty
	a_poll: assert property (p_poll) else $error("polling order broken"); // RQ17

	property p_pending_sticky;
		1'b1 |=> (port1Pending & $past(port1Keep)) == $past(port1Keep);
	endproperty
	a_pending_sticky: assert property (p_pending_sticky) else $error("pending lost"); // RQ12

	property p_level_sets;
		1'b1 |=> (port1Pending & $past(port1Active)) == $past(port1Active);
	endproperty
	a_level_sets: assert property (p_level_sets) else $error("active line not pending"); // RQ9

	property p_wake;
		powerDown && (port1Active & q.enPort1) != '0 |=> wakeUp;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on active line"); // RQ11

	sequence s_return_low;
		retiDone && q.inService == 2'b01 && !acked ##1 (loReq != '0) && !acked;
	endsequence

	property p_rerequest;
		s_return_low |=> coreReq.valid;
	endproperty
	a_rerequest: assert property (p_rerequest) else $error("no request after return"); // RQ13

	property p_en_main_read;
		take && !hwrite && haddr[7:0] == ADDR_EN_MAIN
			|=> ##1 hrdata[7:0] == $past(q.enMain) && (hrdata[6:4] == 3'h0);
	endproperty
	a_en_main_read: assert property (p_en_main_read) else $error("main enable readback"); // RQ5

	property p_lvl_port1_write;
		take && hwrite && haddr[7:0] == ADDR_LVL_PORT1 |=> ##1 q.lvlPort1 == $past(hwdata[7:0]);
	endproperty
	a_lvl_port1_write: assert property (p_lvl_port1_write) else $error("level write lost"); // RQ14

endmodule // twelve_source_two_level_interrupts

`default_nettype wire

// ---- verif/core_model.sv ----
// processor core stand-in: takes presented requests, returns svcLen+1 cycles after the latest ack or return
// assumes the controller's clock and reset; accept lets the bench hold requests back
`default_nettype none

module core_model
	import intc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire core_req_type coreReq,
	input wire logic accept,
	input wire logic [7:0] svcLen,
	output logic ackTake,
	output logic retiDone,
	output logic [3:0] lastSrc,
	output logic [1:0] depth
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ackTake <= 1'b0;
			retiDone <= 1'b0;
			lastSrc <= 4'h0;
			depth <= 2'h0;
			cnt <= 8'h00;
		end else begin
			ackTake <= 1'b0;
			retiDone <= 1'b0;
			// no second ack while the first is still being taken
			if (accept && coreReq.valid && !ackTake) begin
				ackTake <= 1'b1;
				lastSrc <= coreReq.source;
				depth <= depth + 2'h1;
				cnt <= 8'h00;
			end else if (depth != 2'h0) begin
				cnt <= cnt + 8'h01;
				if (cnt == svcLen) begin
					retiDone <= 1'b1;
					depth <= depth - 2'h1;
					cnt <= 8'h00;
				end
			end
		end
	end
endmodule // core_model

`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench: register bus master, pin and timer stimulus, core stand-in
// assumes the controller answers the bus with one wait state
`default_nettype none

module tb_top;
	import intc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, powerDown, accept, ackTake, retiDone;
	logic wakeUp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, extLines, timerOvf, depth;
	logic [2:0] hsize;
	logic [7:0] port1Pins, svcLen, v;
	logic [3:0] lastSrc;
	core_req_type coreReq;
	int nErrors = 0;
	int checkCount = 0;
	int cyc = 0;
	int k;
	logic [7:0] regs [9] = '{ADDR_EN_MAIN, ADDR_LVL_MAIN, ADDR_EN_PORT1, ADDR_LVL_PORT1,
		ADDR_POLARITY, ADDR_PENDING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_EDGE_MODE};
	logic [7:0] msk [5] = '{8'h8f, 8'h7f, 8'hff, 8'hff, 8'hff};

	twelve_source_two_level_interrupts twelve_source_two_level_interrupts_inst (.clk(clk),
		.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .extLines(extLines), .timerOvf(timerOvf), .port1Pins(port1Pins),
		.powerDown(powerDown), .ackTake(ackTake), .retiDone(retiDone), .coreReq(coreReq),
		.wakeUp(wakeUp), .irq(irq));
	core_model core_model_inst (.clk(clk), .rst(rst), .coreReq(coreReq), .accept(accept),
		.svcLen(svcLen), .ackTake(ackTake), .retiDone(retiDone), .lastSrc(lastSrc),
		.depth(depth));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			nErrors = nErrors + 1;
			giveVerdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			nErrors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// entered just after a rising edge; leaves at the edge that ends the data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'h0, d});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
		bus(a, 1'b0, 32'h0);
		chk(w, {24'h0, e}, rd);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulseT(input logic [1:0] t);
		timerOvf <= t;
		@(posedge clk);
		timerOvf <= 2'b00;
	endtask

	function automatic logic [15:0] expVec(input int s);
		return VECTOR_BASE + VECTOR_STEP * 16'(s);
	endfunction

	task automatic chkReq(input int s, input logic hi);
		chk("coreReq", {10'h0, 1'b1, hi, 4'(s), expVec(s)}, {10'h0, coreReq});
	endtask

	initial begin
		void'($urandom(32'hf905));
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		extLines = 2'b11;
		timerOvf = 2'b00;
		port1Pins = 8'hff;
		powerDown = 1'b0;
		accept = 1'b0;
		svcLen = 8'd60;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (k = 0; k < 9; k++) rdc(regs[k], 8'h00, "reset value");
		for (k = 0; k < 5; k++) begin
			v = 8'($urandom);
			wr(regs[k], v);
			rdc(regs[k], v & msk[k], "register");
		end
		wr(8'h40, 8'hff);
		rdc(8'h40, 8'h00, "unmapped");
		for (k = 0; k < 5; k++) wr(regs[k], 8'h00);
		tick(4);
		wr(ADDR_PENDING, 8'hff);
		$display("test registers done");

		wr(ADDR_EN_MAIN, 8'h80);
		for (int p = 0; p < 2; p++) begin
			k = $urandom_range(7, 0);
			// both polarities, one per pass
			v = {8{1'(p)}};
			port1Pins <= ~v;
			wr(ADDR_POLARITY, v);
			wr(ADDR_EN_PORT1, 8'(1 << k));
			wr(ADDR_LVL_PORT1, 8'(1 << k));
			port1Pins <= ~v ^ 8'(1 << k);
			tick(6);
			chkReq(k + 4, 1'b1);
			rdc(ADDR_PENDING, 8'(1 << k), "pending");
			powerDown <= 1'b1;
			tick(3);
			chk("wakeUp", 32'h1, {31'h0, wakeUp});
			powerDown <= 1'b0;
			port1Pins <= ~v;
			tick(6);
			rdc(ADDR_PENDING, 8'(1 << k), "pending held");
			svcLen <= 8'd20;
			accept <= 1'b1;
			tick(32);
			chk("re-request", 32'h1, {30'h0, depth});
			accept <= 1'b0;
			wr(ADDR_PENDING, 8'(1 << k));
			tick(30);
			rdc(ADDR_PENDING, 8'h00, "pending cleared");
			chk("valid", 32'h0, {31'h0, coreReq.valid});
		end
		port1Pins <= 8'hff;
		wr(ADDR_POLARITY, 8'h00);
		wr(ADDR_EN_PORT1, 8'h00);
		wr(ADDR_LVL_PORT1, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_STATUS, 8'h03);
		$display("test port lines done");

		svcLen <= 8'd60;
		accept <= 1'b1;
		wr(ADDR_EN_MAIN, 8'h8a);
		wr(ADDR_LVL_MAIN, 8'h08);
		pulseT(2'b01);
		tick(6);
		chk("depth", 32'h1, {30'h0, depth});
		chk("source", 32'h1, {28'h0, lastSrc});
		pulseT(2'b10);
		tick(6);
		chk("preempt source", 32'h3, {28'h0, lastSrc});
		pulseT(2'b01);
		tick(6);
		chk("nest depth", 32'h2, {30'h0, depth});
		rdc(ADDR_IRQ_STATUS, 8'h02, "preempt event");
		wr(ADDR_IRQ_MASK, 8'h02);
		tick(2);
		chk("irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STATUS, 8'h02);
		tick(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		k = 0;
		while (depth !== 2'h0 && k < 500) begin
			@(posedge clk);
			k++;
		end
		chk("drained", 32'h0, {30'h0, depth});
		$display("test preemption done");

		accept <= 1'b0;
		wr(ADDR_LVL_MAIN, 8'h00);
		wr(ADDR_EN_MAIN, 8'h8f);
		extLines <= 2'b00;
		pulseT(2'b11);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_EN_MAIN, 8'h80 | (8'h0f & (8'h0f << k)));
			tick(5);
			chkReq(k, 1'b0);
		end
		wr(ADDR_EN_MAIN, 8'h8f);
		wr(ADDR_LVL_MAIN, 8'h08);
		tick(3);
		chkReq(3, 1'b1);
		wr(ADDR_EN_MAIN, 8'h0f);
		tick(3);
		chk("gate off", 32'h0, {31'h0, coreReq.valid});
		$display("test polling done");

		extLines <= 2'b11;
		wr(ADDR_EDGE_MODE, 8'h03);
		rdc(ADDR_EDGE_MODE, 8'h03, "edge mode");
		wr(ADDR_LVL_MAIN, 8'h01);
		wr(ADDR_EN_MAIN, 8'h81);
		tick(4);
		chk("no edge yet", 32'h0, {31'h0, coreReq.valid});
		extLines <= 2'b10;
		tick(6);
		chkReq(0, 1'b1);
		svcLen <= 8'd4;
		accept <= 1'b1;
		tick(14);
		accept <= 1'b0;
		chk("edge served once", 32'h0, {30'h0, depth});
		chk("edge flag cleared", 32'h0, {31'h0, coreReq.valid});
		$display("test edge mode done");
		giveVerdict();
	end
endmodule // tb_top

`default_nettype wire
